// ==== design/slice_consts.vh ====
// Shared constants for the logic cell group and its slices.
// Assumes inclusion by bare name from files under design/ and dv/.
`ifndef SLICE_CONSTS_VH
`define SLICE_CONSTS_VH

// ****************************************
// Slice modes
// ****************************************
`define MODE_W           2
`define MODE_LOGIC       2'h0
`define MODE_RIPPLE      2'h1
`define MODE_RAM         2'h2
`define MODE_ROM         2'h3

// ****************************************
// Ripple functions
// ****************************************
`define FN_W             3
`define FN_ADD           3'h0
`define FN_SUB           3'h1
`define FN_ADDSUB        3'h2
`define FN_UPCNT         3'h3
`define FN_DNCNT         3'h4
`define FN_UDCNT         3'h5
`define FN_MULT          3'h6
`define FN_CMP           3'h7

// ****************************************
// Geometry and reset values
// ****************************************
`define TABLE_DEPTH      16
`define ADDR_W           4
`define SLICE_COUNT      4
`define RAM_SLICE_LAST   2
`define SPR_SLICES       3
`define PSEUDO_DUAL_PORT_MEMORY_SLICES      6
`define CNT_RESET        2'h0

`endif

// ==== design/logic_slice.v ====
// One slice: two four-input tables with config load, user write port,
// five-input merge and a two-bit ripple arithmetic unit.
// Assumes config and user writes never occur in the same cycle.
`timescale 1ns/10ps
`include "slice_consts.vh"

module logic_slice #(
   parameter RAM_OK = 1
) (
   input  wire                 clk_i,
   input  wire                 reset_i,
   input  wire [`MODE_W-1:0]   mode_i,
   input  wire [`FN_W-1:0]     fn_i,
   input  wire                 cfg_we_i,
   input  wire [31:0]          cfg_data_i,
   input  wire [3:0]           tbl_in_a_i,
   input  wire [3:0]           tbl_in_b_i,
   input  wire                 sel5_i,
   input  wire                 ram_we_i,
   input  wire [`ADDR_W-1:0]   ram_waddr_i,
   input  wire [1:0]           ram_wdata_i,
   input  wire [1:0]           opa_i,
   input  wire [1:0]           opb_i,
   input  wire                 cin_i,
   input  wire                 sub_i,
   input  wire                 up_i,
   input  wire                 cnt_clr_n_i,
   input  wire                 load_i,
   input  wire [1:0]           load_val_i,
   output wire [1:0]           tbl_out_o,
   output wire                 f5_o,
   output wire [1:0]           sum_o,
   output wire                 cout_o,
   output wire                 gen_o,
   output wire                 prop_o,
   output wire                 ge_o,
   output wire                 ne_o,
   output wire                 le_o,
   output reg  [1:0]           cnt_o
);

   reg  [15:0] table_a;
   reg  [15:0] table_b;
   wire        ram_mode;
   wire [1:0]  b_eff;
   wire        c_in;
   wire [2:0]  sum3;
   wire [1:0]  p_bits;
   wire [1:0]  g_bits;
   reg  [1:0]  next_cnt;

   assign ram_mode = RAM_OK && (mode_i == `MODE_RAM);

   // ****************************************
   // Table storage
   // ****************************************
   // ROM contents only change through the config port
   always @(posedge clk_i) begin
      if (cfg_we_i) begin
         table_a <= cfg_data_i[15:0];
         table_b <= cfg_data_i[31:16];
      end else if (ram_mode && ram_we_i) begin
         table_a[ram_waddr_i] <= ram_wdata_i[0];
         table_b[ram_waddr_i] <= ram_wdata_i[1];
      end
   end

   // Read is combinational, no clock in the path
   assign tbl_out_o = {table_b[tbl_in_b_i], table_a[tbl_in_a_i]};
   assign f5_o      = sel5_i ? tbl_out_o[1] : tbl_out_o[0];

   // ****************************************
   // Ripple arithmetic
   // ****************************************
   // Subtract as add of inverted operand with carry in forced
   assign b_eff = ((fn_i == `FN_SUB) || (fn_i == `FN_CMP) ||
                  ((fn_i == `FN_ADDSUB) && sub_i)) ? ~opb_i : opb_i;
   assign c_in  = ((fn_i == `FN_SUB) || (fn_i == `FN_CMP) ||
                  ((fn_i == `FN_ADDSUB) && sub_i)) ? 1'b1 : cin_i;
   // Multiplier step: partial product gated by cin as multiplier bit
   assign sum3  = (fn_i == `FN_MULT) ?
                  {1'b0, opa_i} + {1'b0, opb_i & {2{cin_i}}} :
                  {1'b0, opa_i} + {1'b0, b_eff} + {2'h0, c_in};
   assign sum_o  = sum3[1:0];
   assign cout_o = sum3[2];
   assign p_bits = opa_i ^ b_eff;
   assign g_bits = opa_i & b_eff;
   assign prop_o = &p_bits;
   assign gen_o  = g_bits[1] | (p_bits[1] & g_bits[0]);
   assign ge_o   = (opa_i >= opb_i);
   assign ne_o   = (opa_i != opb_i);
   assign le_o   = (opa_i <= opb_i);

   // ****************************************
   // Counter
   // ****************************************
   always @* begin
      next_cnt = cnt_o;
      if (mode_i == `MODE_RIPPLE) begin
         case (fn_i)
            `FN_UPCNT: next_cnt = cnt_o + 2'h1;
            `FN_DNCNT: next_cnt = cnt_o - 2'h1;
            `FN_UDCNT: begin
               if (load_i)
                  next_cnt = load_val_i;
               else if (up_i)
                  next_cnt = cnt_o + 2'h1;
               else
                  next_cnt = cnt_o - 2'h1;
            end
            default: next_cnt = cnt_o;
         endcase
      end
   end

   // Clear acts without the clock, as a fabric counter clear would
   always @(posedge clk_i or negedge cnt_clr_n_i) begin
      if (!cnt_clr_n_i)
         cnt_o <= `CNT_RESET;
      else if (reset_i)
         cnt_o <= `CNT_RESET;
      else
         cnt_o <= next_cnt;
   end

endmodule

// ==== design/logic_cell_group.v ====
// Logic cell group: four slices with logic, ripple, RAM and ROM modes,
// a 16x4 single-port memory and a 16x2 pseudo dual-port memory.
// Assumes user logic drives all inputs synchronous to clk_i.
`timescale 1ns/10ps
`include "slice_consts.vh"

// Notes on behaviour
// - Slices 0-2 all modes, slice 3 no RAM
// - Each table is a 16-entry four-input function
// - Two tables of a slice form five-input function
// - Chained slices give six and seven inputs
// - Two-bit add, subtract and dynamic add/subtract
// - Up, down, cleared and preloaded two-bit counters
// - Compare gives ge, ne and le
// - Slices chain as multiplier building blocks
// - Fast carry gives generate and propagate
// - Slices 0 and 1 hold 16x2 each
// - Slice 2 supplies address and control
// - Pseudo dual port: read-write plus read-only slice
// - One write updates both slices together
// - Memories take initial contents before use
// - Single port three slices, dual port six
// - All four slices usable as ROM
module logic_cell_group #(
   parameter NSLICE = `SLICE_COUNT
) (
   input  wire                  clk_i,
   input  wire                  reset_i,
   input  wire [2*NSLICE-1:0]   slice_mode_i,
   input  wire [3*NSLICE-1:0]   slice_fn_i,
   input  wire [NSLICE-1:0]     cfg_we_i,
   input  wire [31:0]           cfg_data_i,
   input  wire [8*NSLICE-1:0]   lut_in_i,
   input  wire [NSLICE-1:0]     sel5_i,
   input  wire [1:0]            chain_sel_i,
   input  wire                  spr_we_i,
   input  wire [`ADDR_W-1:0]    spr_addr_i,
   input  wire [3:0]            spr_wdata_i,
   input  wire                  pdp_we_i,
   input  wire [`ADDR_W-1:0]    pdp_waddr_i,
   input  wire [`ADDR_W-1:0]    pdp_raddr_i,
   input  wire [1:0]            pdp_wdata_i,
   input  wire [2*NSLICE-1:0]   opa_i,
   input  wire [2*NSLICE-1:0]   opb_i,
   input  wire                  carry_in_i,
   input  wire                  sub_i,
   input  wire                  up_i,
   input  wire                  cnt_clr_n_i,
   input  wire                  load_i,
   input  wire [2*NSLICE-1:0]   load_val_i,
   output wire [2*NSLICE-1:0]   lut_out_o,
   output wire [NSLICE-1:0]     five_input_table_o,
   output wire                  eight_input_table_o,
   output wire [3:0]            single_port_memory_o,
   output wire [1:0]            pdp_rw_data_o,
   output wire [1:0]            pdp_ro_data_o,
   output wire [2*NSLICE-1:0]   sum_o,
   output wire                  carry_out_o,
   output wire                  group_gen_o,
   output wire                  group_prop_o,
   output wire                  ge_o,
   output wire                  ne_o,
   output wire                  le_o,
   output wire [2*NSLICE-1:0]   cnt_o
);

   wire [NSLICE:0]     carry;
   wire [NSLICE-1:0]   gen;
   wire [NSLICE-1:0]   prop;
   wire [NSLICE-1:0]   ge_s;
   wire [NSLICE-1:0]   ne_s;
   wire [NSLICE-1:0]   le_s;
   wire [2*NSLICE-1:0] tbl_out;
   wire [NSLICE-1:0]   f5;
   reg  [1:0]          f5_chain;

   // ****************************************
   // Slice 2 as address and control source
   // ****************************************
   // Slice 2 decodes which storage slice gets the write strobe;
   // in single-port use slices 0 and 1 both store. With slice 2
   // idle, slice 0 in RAM mode is the pdp read-write port, since
   // slice 3 can never take user writes.
   wire spr_en   = (slice_mode_i[5:4] == `MODE_RAM);
   wire pdp_en   = !spr_en && (slice_mode_i[1:0] == `MODE_RAM);
   wire [3:0] spr_rd_addr = spr_addr_i;

   assign carry[0] = carry_in_i;

   genvar i;
   generate
      for (i = 0; i < NSLICE; i = i + 1) begin : g_slice
         wire       is_spr = (i < 2) && spr_en;
         wire       is_pdp = (i == 0) && pdp_en;
         wire       we     = is_spr ? spr_we_i :
                             is_pdp ? pdp_we_i : 1'b0;
         wire [3:0] waddr  = is_pdp ? pdp_waddr_i : spr_addr_i;
         wire [1:0] wdata  = is_spr ? spr_wdata_i[2*(i%2)+1:2*(i%2)] :
                             pdp_wdata_i;
         // Memory address overrides table inputs of slices 0 and 1 in single-port use, and of slice 0 alone in pdp use
         wire [3:0] rd_a   = is_spr ? spr_rd_addr :
                             is_pdp ? pdp_waddr_i : lut_in_i[8*i+3:8*i];
         wire [3:0] rd_b   = is_spr ? spr_rd_addr :
                             is_pdp ? pdp_waddr_i : lut_in_i[8*i+7:8*i+4];
         logic_slice #(
            .RAM_OK (i <= `RAM_SLICE_LAST)
         ) u_slice (
            .clk_i       (clk_i),
            .reset_i     (reset_i),
            .mode_i      (slice_mode_i[2*i+1:2*i]),
            .fn_i        (slice_fn_i[3*i+2:3*i]),
            .cfg_we_i    (cfg_we_i[i]),
            .cfg_data_i  (cfg_data_i),
            .tbl_in_a_i  (rd_a),
            .tbl_in_b_i  (rd_b),
            .sel5_i      (sel5_i[i]),
            .ram_we_i    (we),
            .ram_waddr_i (waddr),
            .ram_wdata_i (wdata),
            .opa_i       (opa_i[2*i+1:2*i]),
            .opb_i       (opb_i[2*i+1:2*i]),
            .cin_i       (carry[i]),
            .sub_i       (sub_i),
            .up_i        (up_i),
            .cnt_clr_n_i (cnt_clr_n_i),
            .load_i      (load_i),
            .load_val_i  (load_val_i[2*i+1:2*i]),
            .tbl_out_o   (tbl_out[2*i+1:2*i]),
            .f5_o        (f5[i]),
            .sum_o       (sum_o[2*i+1:2*i]),
            .cout_o      (carry[i+1]),
            .gen_o       (gen[i]),
            .prop_o      (prop[i]),
            .ge_o        (ge_s[i]),
            .ne_o        (ne_s[i]),
            .le_o        (le_s[i]),
            .cnt_o       (cnt_o[2*i+1:2*i])
         );
      end
   endgenerate

   assign lut_out_o          = tbl_out;
   assign five_input_table_o = f5;
   assign carry_out_o        = carry[NSLICE];

   // ****************************************
   // Wide functions by chaining slices
   // ****************************************
   // Pairs of five-input outputs merge into six and seven inputs;
   // the eighth input needs a further merge outside this group.
   always @* begin
      f5_chain[0] = chain_sel_i[0] ? f5[1] : f5[0];
      f5_chain[1] = chain_sel_i[0] ? f5[3] : f5[2];
   end
   assign eight_input_table_o = chain_sel_i[1] ? f5_chain[1] :
                                f5_chain[0];

   // ****************************************
   // Group carry lookahead
   // ****************************************
   assign group_prop_o = &prop;
   assign group_gen_o  = gen[3] | (prop[3] & gen[2]) |
                         (prop[3] & prop[2] & gen[1]) |
                         (prop[3] & prop[2] & prop[1] & gen[0]);

   // Compare across the whole word from the top slice down
   wire [2*NSLICE-1:0] a_w = opa_i;
   wire [2*NSLICE-1:0] b_w = opb_i;
   assign ge_o = (a_w >= b_w);
   assign ne_o = |ne_s;
   assign le_o = (a_w <= b_w);

   // ****************************************
   // Memory read ports
   // ****************************************
   // Combinational read: address in, data out same cycle
   assign single_port_memory_o = {tbl_out[3:2], tbl_out[1:0]};
   // Read-write port is slice 0 at write address; read-only port is
   // its companion, fed by the same config and pdp writes; single-port writes reach slices 0 and 1, not the companion.
   assign pdp_rw_data_o = tbl_out[1:0];

   // Companion read-only copy, written in the same cycle
   reg [1:0] ro_mem [0:`TABLE_DEPTH-1];
   integer k;
   always @(posedge clk_i) begin
      if (cfg_we_i[0]) begin
         for (k = 0; k < `TABLE_DEPTH; k = k + 1)
            ro_mem[k] <= {cfg_data_i[16+k], cfg_data_i[k]};
      end else if (pdp_en && pdp_we_i) begin
         ro_mem[pdp_waddr_i] <= pdp_wdata_i;
      end
   end

   function [1:0] ro_table;
      input [`ADDR_W-1:0] a;
      begin
         ro_table = ro_mem[a];
      end
   endfunction

   assign pdp_ro_data_o = ro_table(pdp_raddr_i);

endmodule

// ==== dv/cell_group_monitor.sv ====
// Checker on the logic cell group ports.
// Assumes a bind into logic_cell_group and one clock domain.
`timescale 1ns/10ps
`include "slice_consts.vh"

module cell_group_monitor #(
   parameter NSLICE = 4
) (
   input wire                 clk_i,
   input wire                 reset_i,
   input wire [2*NSLICE-1:0]  slice_mode_i,
   input wire [3*NSLICE-1:0]  slice_fn_i,
   input wire [NSLICE-1:0]    cfg_we_i,
   input wire                 spr_we_i,
   input wire [`ADDR_W-1:0]   spr_addr_i,
   input wire [3:0]           spr_wdata_i,
   input wire                 pdp_we_i,
   input wire [`ADDR_W-1:0]   pdp_waddr_i,
   input wire [`ADDR_W-1:0]   pdp_raddr_i,
   input wire [1:0]           pdp_wdata_i,
   input wire [2*NSLICE-1:0]  opa_i,
   input wire [2*NSLICE-1:0]  opb_i,
   input wire                 carry_in_i,
   input wire                 cnt_clr_n_i,
   input wire                 load_i,
   input wire [2*NSLICE-1:0]  load_val_i,
   input wire [3:0]           single_port_memory_o,
   input wire [1:0]           pdp_rw_data_o,
   input wire [1:0]           pdp_ro_data_o,
   input wire [2*NSLICE-1:0]  sum_o,
   input wire                 ge_o,
   input wire                 ne_o,
   input wire                 le_o,
   input wire [2*NSLICE-1:0]  cnt_o
);
   // ********
   // Helpers
   // ********
   wire       ripple0 = slice_mode_i[1:0] == `MODE_RIPPLE;
   wire [1:0] add_exp = opa_i[1:0] + opb_i[1:0] + {1'b0, carry_in_i};
   wire       all_cmp = slice_fn_i == {NSLICE{`FN_CMP}} &&
                        slice_mode_i == {NSLICE{`MODE_RIPPLE}};
   wire       pdp_on  = slice_mode_i[5:4] != `MODE_RAM && cfg_we_i == 0 &&
                        slice_mode_i[1:0] == `MODE_RAM;

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence spr_write;
      slice_mode_i[5:4] == `MODE_RAM && spr_we_i && cfg_we_i == 0;
   endsequence
   sequence pdp_write;
      pdp_on && pdp_we_i;
   endsequence
   // Clear must stay high over both edges, it overrides any step
   property cnt_step(logic [2:0] f, logic [1:0] d);
      ripple0 && slice_fn_i[2:0] == f && !load_i && cnt_clr_n_i
         ##1 cnt_clr_n_i |-> cnt_o[1:0] == $past(cnt_o[1:0]) + d;
   endproperty

   // ********
   // Checks
   // ********
   reset_clear_a: assert property (disable iff (1'b0)
      reset_i |=> cnt_o == '0) else $error("counter not zero after reset");
   async_clear_a: assert property (!cnt_clr_n_i |-> cnt_o == '0)
      else $error("counter not held clear");
   count_up_a: assert property (cnt_step(`FN_UPCNT, 2'h1))
      else $error("up count step wrong");
   count_down_a: assert property (cnt_step(`FN_DNCNT, 2'h3))
      else $error("down count step wrong");
   count_load_a: assert property (ripple0 && load_i && cnt_clr_n_i
      && slice_fn_i[2:0] == `FN_UDCNT ##1 cnt_clr_n_i
      |-> cnt_o[1:0] == $past(load_val_i[1:0])) else $error("preload lost");
   add_sum_a: assert property (ripple0 && slice_fn_i[2:0] == `FN_ADD
      |-> sum_o[1:0] == add_exp) else $error("two-bit sum wrong");
   compare_flags_a: assert property (all_cmp |-> ge_o == (opa_i >= opb_i)
      && ne_o == (opa_i != opb_i) && le_o == (opa_i <= opb_i))
      else $error("compare flags wrong");
   spr_read_a: assert property (spr_write ##1 $stable(spr_addr_i)
      |-> single_port_memory_o == $past(spr_wdata_i))
      else $error("single port read-back wrong");
   pdp_mirror_a: assert property (pdp_write ##1
      pdp_raddr_i == $past(pdp_waddr_i) && $stable(pdp_waddr_i)
      |-> pdp_ro_data_o == $past(pdp_wdata_i)
      && pdp_rw_data_o == $past(pdp_wdata_i)) else $error("copies differ");
endmodule

// ==== dv/fabric_cfg_model.sv ====
// Far-side model: loader that presets table and ROM contents.
// Assumes go_i is raised once after reset, before user traffic.
`timescale 1ns/10ps

module fabric_cfg_model #(
   parameter [31:0] ROM_IMG  = 32'h0000_FFFF,
   parameter [31:0] INIT_IMG = 32'hFFFF_0000
) (
   input  wire        clk_i,
   input  wire        go_i,
   output reg  [3:0]  cfg_we_o,
   output reg  [31:0] cfg_data_o,
   output reg         done_o
);
   reg [1:0] step = 2'h0;

   initial begin
      cfg_we_o = 4'h0;
      cfg_data_o = 32'h0;
      done_o = 1'b0;
   end

   // ********
   // Loader
   // ********
   // Idle word flips so a stale word never passes for a load
   always @(posedge clk_i) begin
      if (step == 2'h0 && go_i) begin
         cfg_we_o <= 4'h8;
         cfg_data_o <= ROM_IMG;
      end else if (step == 2'h1) begin
         cfg_we_o <= 4'h1;
         cfg_data_o <= INIT_IMG;
      end else begin
         cfg_we_o <= 4'h0;
         cfg_data_o <= ~cfg_data_o;
      end
      if (step == 2'h2)
         done_o <= 1'b1;
      if ((step != 2'h0 || go_i) && step != 2'h3)
         step <= step + 2'h1;
   end
endmodule

// ==== dv/logic_cell_group_test.sv ====
// Self-checking bench for the logic cell group.
// Assumes the design, checker and loader model are compiled with it.
`timescale 1ns/10ps
`include "slice_consts.vh"

module logic_cell_group_test;
   localparam [31:0] ROM_IMG  = 32'h5A3C_96F0;
   localparam [31:0] INIT_IMG = 32'hC3A5_0FF1;
   reg         clk_i = 1'b0;
   reg         reset_i = 1'b1;
   reg  [7:0]  slice_mode_i = 8'h00;
   reg  [11:0] slice_fn_i = 12'h000;
   reg  [31:0] lut_in_i = 32'h0;
   reg         spr_we_i = 1'b0;
   reg  [3:0]  spr_addr_i = 4'h0;
   reg  [3:0]  spr_wdata_i = 4'h0;
   reg         pdp_we_i = 1'b0;
   reg  [3:0]  pdp_waddr_i = 4'h0;
   reg  [3:0]  pdp_raddr_i = 4'h0;
   reg  [1:0]  pdp_wdata_i = 2'h0;
   reg  [7:0]  opa_i = 8'h00;
   reg  [7:0]  opb_i = 8'h00;
   reg         sub_i = 1'b0;
   reg         up_i = 1'b1;
   reg         cnt_clr_n_i = 1'b1;
   reg         load_i = 1'b0;
   reg  [7:0]  load_val_i = 8'h00;
   reg         go = 1'b0;
   reg  [3:0]  sel5_i = 4'h0;
   reg  [1:0]  chain_sel_i = 2'h0;
   reg         carry_in_i = 1'b0;
   reg  [1:0]  f5e;
   wire        done;
   wire [3:0]  five_input_table_o;
   wire        eight_input_table_o;
   wire        carry_out_o;
   wire        group_gen_o;
   wire        group_prop_o;
   wire [2:0]  wide_fn;
   wire [10:0] fast_carry;
   wire [3:0]  cfg_we_i;
   wire [31:0] cfg_data_i;
   wire [7:0]  lut_out_o;
   wire [7:0]  sum_o;
   wire [7:0]  cnt_o;
   wire [3:0]  single_port_memory_o;
   wire [1:0]  pdp_rw_data_o;
   wire [1:0]  pdp_ro_data_o;
   wire        ge_o;
   wire        ne_o;
   wire        le_o;
   reg  [12:0] rows [0:9];
   reg  [2:0]  f;
   reg  [1:0]  a;
   reg  [1:0]  b;
   reg         s;
   reg  [1:0]  es;
   reg  [2:0]  ec;
   reg  [3:0]  e;
   integer     num_errors = 0;
   integer     tests_run = 0;
   integer     i;

   always #10 clk_i = ~clk_i;

   fabric_cfg_model #(.ROM_IMG(ROM_IMG), .INIT_IMG(INIT_IMG))
      fabric_cfg_model_i (.clk_i, .go_i(go), .cfg_we_o(cfg_we_i),
      .cfg_data_o(cfg_data_i), .done_o(done));

   logic_cell_group logic_cell_group_i (
      .clk_i, .reset_i, .slice_mode_i, .slice_fn_i, .cfg_we_i, .cfg_data_i,
      .lut_in_i, .sel5_i, .chain_sel_i, .spr_we_i, .spr_addr_i,
      .spr_wdata_i, .pdp_we_i, .pdp_waddr_i, .pdp_raddr_i, .pdp_wdata_i,
      .opa_i, .opb_i, .carry_in_i, .sub_i, .up_i, .cnt_clr_n_i,
      .load_i, .load_val_i, .lut_out_o, .five_input_table_o,
      .eight_input_table_o, .single_port_memory_o, .pdp_rw_data_o,
      .pdp_ro_data_o, .sum_o, .carry_out_o, .group_gen_o,
      .group_prop_o, .ge_o, .ne_o, .le_o, .cnt_o);

   assign wide_fn    = {eight_input_table_o, five_input_table_o[3],
                        five_input_table_o[0]};
   assign fast_carry = {carry_out_o, group_prop_o, group_gen_o, sum_o};

   // ********
   // Checking and closing
   // ********
   task check(input logic [31:0] got, input logic [31:0] exp,
              input [8*12:1] what);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0s expected %0h seen %0h", what, exp, got);
         end
      end
   endtask

   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   // Whole run needs well under 100 cycles
   initial begin
      #20000;
      num_errors = num_errors + 1;
      report_and_stop;
   end

   // ********
   // Tests
   // ********
   initial begin
      rows[0] = {`FN_ADD, 2'h3, 2'h2, 1'h0, 2'h1, 3'h0};
      rows[1] = {`FN_ADD, 2'h1, 2'h1, 1'h0, 2'h2, 3'h0};
      rows[2] = {`FN_SUB, 2'h1, 2'h2, 1'h0, 2'h3, 3'h0};
      rows[3] = {`FN_ADDSUB, 2'h3, 2'h1, 1'h1, 2'h2, 3'h0};
      rows[4] = {`FN_ADDSUB, 2'h2, 2'h1, 1'h0, 2'h3, 3'h0};
      rows[5] = {`FN_CMP, 2'h2, 2'h1, 1'h0, 2'h0, 3'h6};
      rows[6] = {`FN_CMP, 2'h1, 2'h1, 1'h0, 2'h0, 3'h5};
      rows[7] = {`FN_CMP, 2'h0, 2'h3, 1'h0, 2'h0, 3'h3};
      rows[8] = {`FN_MULT, 2'h1, 2'h2, 1'h1, 2'h3, 3'h0};
      rows[9] = {`FN_ADD, 2'h2, 2'h1, 1'h1, 2'h0, 3'h0};
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(negedge clk_i);
      check(cnt_o, 8'h00, "cnt reset");
      for (i = 0; i < 8 && !done; i = i + 1)
         @(posedge clk_i);
      for (i = 0; i < 16; i = i + 1) begin
         @(posedge clk_i);
         slice_mode_i <= {`MODE_ROM, {3{`MODE_LOGIC}}};
         lut_in_i <= {8{i[3:0]}};
         sel5_i <= {4{i[0]}};
         chain_sel_i <= {2{i[1]}};
         e = {ROM_IMG[16+i], ROM_IMG[i], INIT_IMG[16+i], INIT_IMG[i]};
         f5e = {ROM_IMG[16*i[0]+i], INIT_IMG[16*i[0]+i]};
         @(negedge clk_i);
         check({lut_out_o[7:6], lut_out_o[1:0]}, e, "tables");
         check(wide_fn, {f5e[i[1]], f5e}, "wide table");
      end
      $display("test tables done");
      for (i = 0; i < 10; i = i + 1) begin
         @(posedge clk_i);
         {f, a, b, s, es, ec} = rows[i];
         slice_mode_i <= {4{`MODE_RIPPLE}};
         slice_fn_i <= {4{f}};
         opa_i <= {4{a}};
         opb_i <= {4{b}};
         sub_i <= s;
         carry_in_i <= s;
         @(negedge clk_i);
         if (f == `FN_CMP)
            check({ge_o, ne_o, le_o}, ec, "compare");
         else
            check(sum_o[1:0], es, "sum");
      end
      $display("test ripple rows done");
      @(posedge clk_i);
      slice_fn_i <= {4{`FN_ADD}};
      opa_i <= 8'hFF;
      opb_i <= 8'h00;
      carry_in_i <= 1'b1;
      @(negedge clk_i);
      check(fast_carry, 11'h600, "fast carry");
      @(posedge clk_i);
      opa_i <= 8'h80;
      opb_i <= 8'h80;
      carry_in_i <= 1'b0;
      @(negedge clk_i);
      check(fast_carry, 11'h500, "fast carry");
      $display("test fast carry done");
      @(posedge clk_i);
      reset_i <= 1'b1;
      slice_fn_i <= {4{`FN_UPCNT}};
      @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      check(cnt_o, 8'h00, "cnt rereset");
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      check(cnt_o[1:0], 2'h3, "cnt up");
      @(posedge clk_i);
      slice_fn_i <= {4{`FN_DNCNT}};
      @(posedge clk_i);
      @(negedge clk_i);
      check(cnt_o[1:0], 2'h3, "cnt down");
      @(posedge clk_i);
      slice_fn_i <= {4{`FN_UDCNT}};
      up_i <= 1'b0;
      load_i <= 1'b1;
      load_val_i <= 8'h9A;
      @(posedge clk_i);
      load_i <= 1'b0;
      @(negedge clk_i);
      check(cnt_o[1:0], 2'h2, "cnt load");
      @(posedge clk_i);
      slice_fn_i <= {4{`FN_ADD}};
      @(negedge clk_i);
      check(cnt_o[1:0], 2'h1, "cnt updown");
      @(posedge clk_i);
      cnt_clr_n_i <= 1'b0;
      @(negedge clk_i);
      check(cnt_o, 8'h00, "cnt clear");
      $display("test counters done");
      @(posedge clk_i);
      cnt_clr_n_i <= 1'b1;
      slice_mode_i <= {`MODE_LOGIC, {3{`MODE_RAM}}};
      spr_we_i <= 1'b1;
      spr_addr_i <= 4'h5;
      spr_wdata_i <= 4'hA;
      @(posedge clk_i);
      spr_addr_i <= 4'h6;
      spr_wdata_i <= 4'h3;
      @(posedge clk_i);
      spr_we_i <= 1'b0;
      @(negedge clk_i);
      check(single_port_memory_o, 4'h3, "spr word 6");
      @(posedge clk_i);
      spr_addr_i <= 4'h5;
      @(negedge clk_i);
      check(single_port_memory_o, 4'hA, "spr word 5");
      $display("test single port done");
      @(posedge clk_i);
      slice_mode_i <= {{3{`MODE_LOGIC}}, `MODE_RAM};
      pdp_we_i <= 1'b1;
      pdp_waddr_i <= 4'h9;
      pdp_raddr_i <= 4'h9;
      pdp_wdata_i <= 2'h2;
      @(posedge clk_i);
      pdp_wdata_i <= 2'h1;
      @(negedge clk_i);
      check({pdp_rw_data_o, pdp_ro_data_o}, 4'hA, "pdp ports");
      @(posedge clk_i);
      pdp_we_i <= 1'b0;
      pdp_waddr_i <= 4'h3;
      @(negedge clk_i);
      e = {INIT_IMG[19], INIT_IMG[3], 2'h1};
      check({pdp_rw_data_o, pdp_ro_data_o}, e, "pdp read");
      $display("test dual port done");
      report_and_stop;
   end
endmodule

bind logic_cell_group cell_group_monitor #(.NSLICE(NSLICE))
   cell_group_monitor_i (
   .clk_i, .reset_i, .slice_mode_i, .slice_fn_i, .cfg_we_i, .spr_we_i,
   .spr_addr_i, .spr_wdata_i, .pdp_we_i, .pdp_waddr_i, .pdp_raddr_i,
   .pdp_wdata_i, .opa_i, .opb_i, .carry_in_i, .cnt_clr_n_i, .load_i,
   .load_val_i, .single_port_memory_o, .pdp_rw_data_o, .pdp_ro_data_o,
   .sum_o, .ge_o, .ne_o, .le_o, .cnt_o);
